// [verilog/ecs_defines.svh]
// Purpose: constants of the encoder command interpreter and status reporter
// Assumes: byte link receiver on the same clock feeds bytes and a frame-end strobe
// Notes: status codes, commands and the key, address and mode reset values live here as macros
`ifndef ECS_DEFINES_SVH
`define ECS_DEFINES_SVH

`define ECS_ST_OK 8'h00
`define ECS_ST_INIT_LO 8'h01
`define ECS_ST_INIT_HI 8'h06
`define ECS_ST_WDOG 8'h07
`define ECS_ST_CNT_OVF 8'h08
`define ECS_ST_PARITY 8'h09
`define ECS_ST_CHKSUM 8'h0a
`define ECS_ST_UNK_CMD 8'h0b
`define ECS_ST_LEN 8'h0c
`define ECS_ST_BAD_ARG 8'h0d
`define ECS_ST_RO 8'h0e
`define ECS_ST_KEY 8'h0f
`define ECS_ST_RESIZE 8'h10
`define ECS_ST_RANGE 8'h11
`define ECS_ST_NO_FIELD 8'h12
`define ECS_ST_ANALOG 8'h1c
`define ECS_ST_TEMP 8'h1e
`define ECS_ST_SPEED 8'h1f
`define ECS_ST_ST_POS 8'h20
`define ECS_ST_MT_POS 8'h21

`define ECS_C_RD_POS 8'h42
`define ECS_C_SET_POS 8'h43
`define ECS_C_RD_ANA 8'h44
`define ECS_C_RD_CNT 8'h46
`define ECS_C_INC_CNT 8'h47
`define ECS_C_DEL_CNT 8'h49
`define ECS_C_RD_DATA 8'h4a
`define ECS_C_ST_DATA 8'h4b
`define ECS_C_FLD_STAT 8'h4c
`define ECS_C_MK_FLD 8'h4d
`define ECS_C_FREE 8'h4e
`define ECS_C_NEW_KEY 8'h4f
`define ECS_C_STATUS 8'h50
`define ECS_C_TYPE 8'h52
`define ECS_C_RESET 8'h53
`define ECS_C_SET_ADDR 8'h55
`define ECS_C_SERIAL 8'h56
`define ECS_C_LINK_CFG 8'h57

`define ECS_KEY_RST 8'h55
`define ECS_ADDR_RST 8'h40
`define ECS_MODE_RST 8'he4
`define ECS_CH_A 8'h48
`define ECS_CH_B 8'hf0
`define ECS_BUF_LEN 4'h8
`define ECS_CNT_MAX 4'hf

`endif

// [verilog/ecs_pkg.sv]
// Purpose: types shared by the encoder command interpreter
// Assumes: nothing beyond the defines header
// Notes: types only, constants are macros
package ecs_pkg;
	typedef logic [7:0] ecs_byte_t;
	typedef enum logic {ECS_IDLE, ECS_RX} ecs_state_e;
endpackage

// [verilog/ecs_top.sv]
// Purpose: decodes link frames, checks them, executes settings, reports status
// Assumes: frame_end_i never in the same cycle as rx_valid_i
// Notes: frame = address, command, arguments, xor checksum
`timescale 1ns/1ps
`include "ecs_defines.svh"

module ecs_top import ecs_pkg::*; #(
	parameter int NUM_FIELDS = 4,
	parameter logic [10:0] FREE_BYTES = 11'd1792,
	parameter logic [7:0] TYPE_ID = 8'h5a, // arbitrary value
	parameter logic [15:0] SERIAL_ID = 16'h1234 // arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic rx_valid_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic rx_par_err_i,
	input wire logic frame_end_i,
	input wire logic init_fault_i,
	input wire logic [2:0] init_code_i,
	input wire logic wdog_restart_i,
	input wire logic cnt_ovf_i,
	input wire logic speed_fault_i,
	input wire logic st_fault_i,
	input wire logic mt_fault_i,
	input wire logic [1:0] mt_code_i,
	input wire logic analog_fault_i,
	input wire logic temp_fault_i,
	output logic resp_valid_o,
	output logic [7:0] resp_cmd_o,
	output logic [7:0] resp_code_o,
	output logic [15:0] resp_data_o,
	output logic exec_valid_o,
	output logic [7:0] exec_cmd_o,
	output logic [31:0] exec_arg_o,
	output logic soft_reset_o,
	output logic [7:0] bus_addr_o,
	output logic [7:0] link_mode_o,
	output logic [7:0] status_o
);
	localparam int FW = (NUM_FIELDS > 1) ? $clog2(NUM_FIELDS) : 1;

	// field table indexes with a small select, keep it bounded
	if (NUM_FIELDS < 1 || NUM_FIELDS > 16) begin : g_chk
		$error("ecs_top: NUM_FIELDS must be 1 to 16");
	end

	ecs_state_e state_ff;
	ecs_byte_t buf_ff [0:7];
	logic [3:0] cnt_ff;
	logic par_ff;
	ecs_byte_t chk_ff;
	ecs_byte_t key_ff;
	logic [6:0] size_ff [0:NUM_FIELDS-1];
	logic ro_ff [0:NUM_FIELDS-1];
	logic [10:0] free_ff;

	ecs_byte_t cmd, fb, wb, err_code, ev_code;
	logic [3:0] exp_len;
	logic prot, is_fld, is_acc, fexist, ev_valid;
	logic [FW-1:0] fi;
	logic frame_go, ok_go;
	logic [15:0] nxt_data;

	// frame collection; bytes past the buffer only count, so length check sees them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= ECS_IDLE;
			cnt_ff <= 4'h0;
			par_ff <= 1'b0;
			chk_ff <= 8'h00;
		end else if (frame_end_i) begin
			state_ff <= ECS_IDLE;
			cnt_ff <= 4'h0;
			par_ff <= 1'b0;
			chk_ff <= 8'h00;
		end else if (rx_valid_i) begin
			state_ff <= ECS_RX;
			if (cnt_ff != `ECS_CNT_MAX) begin
				cnt_ff <= cnt_ff + 4'h1;
			end
			chk_ff <= chk_ff ^ rx_byte_i;
			par_ff <= par_ff | rx_par_err_i;
		end
	end

	// buffer store, no reset needed: length count guards stale bytes
	always_ff @(posedge clk_i) begin
		if (rx_valid_i && !frame_end_i && cnt_ff < `ECS_BUF_LEN) begin
			buf_ff[cnt_ff[2:0]] <= rx_byte_i;
		end
	end

	// frames to other addresses are dropped without an answer
	assign frame_go = frame_end_i && state_ff == ECS_RX && buf_ff[0] == bus_addr_o;
	assign ok_go = frame_go && err_code == `ECS_ST_OK;

	// command table: total frame length and key protection
	always_comb begin
		cmd = buf_ff[1];
		prot = 1'b0;
		case (cmd)
			`ECS_C_RD_POS, `ECS_C_RD_CNT, `ECS_C_INC_CNT, `ECS_C_FREE,
			`ECS_C_STATUS, `ECS_C_TYPE, `ECS_C_RESET, `ECS_C_SERIAL: exp_len = 4'h3;
			`ECS_C_RD_ANA, `ECS_C_FLD_STAT: exp_len = 4'h4;
			`ECS_C_RD_DATA: exp_len = 4'h5;
			`ECS_C_SET_POS: begin
				exp_len = 4'h8;
				prot = 1'b1;
			end
			`ECS_C_DEL_CNT: begin
				exp_len = 4'h4;
				prot = 1'b1;
			end
			`ECS_C_ST_DATA: begin
				exp_len = 4'h7;
				prot = 1'b1;
			end
			`ECS_C_MK_FLD: begin
				exp_len = 4'h6;
				prot = 1'b1;
			end
			`ECS_C_NEW_KEY, `ECS_C_SET_ADDR, `ECS_C_LINK_CFG: begin
				exp_len = 4'h5;
				prot = 1'b1;
			end
			default: exp_len = 4'h0; // unknown command
		endcase
	end

	// field operands sit after the key byte on protected commands
	always_comb begin
		is_acc = cmd == `ECS_C_RD_DATA || cmd == `ECS_C_ST_DATA;
		is_fld = is_acc || cmd == `ECS_C_FLD_STAT || cmd == `ECS_C_MK_FLD;
		fb = (cmd == `ECS_C_RD_DATA || cmd == `ECS_C_FLD_STAT) ? buf_ff[2] : buf_ff[3];
		wb = (cmd == `ECS_C_RD_DATA) ? buf_ff[3] : buf_ff[4];
		fexist = fb < 8'(NUM_FIELDS);
		fi = fb[FW-1:0];
	end

	// checks in fixed priority; first failing check names the fault
	always_comb begin
		if (par_ff) begin
			err_code = `ECS_ST_PARITY;
		end else if (cnt_ff < 4'h2) begin
			err_code = `ECS_ST_LEN;
		end else if (chk_ff != 8'h00) begin
			err_code = `ECS_ST_CHKSUM;
		end else if (exp_len == 4'h0) begin
			err_code = `ECS_ST_UNK_CMD;
		end else if (cnt_ff != exp_len) begin
			err_code = `ECS_ST_LEN;
		end else if (prot && buf_ff[2] != key_ff) begin
			err_code = `ECS_ST_KEY;
		end else if (is_fld && !fexist) begin
			err_code = `ECS_ST_NO_FIELD;
		end else if (is_acc && size_ff[fi] == 7'h00) begin
			err_code = `ECS_ST_NO_FIELD;
		end else if (cmd == `ECS_C_ST_DATA && ro_ff[fi]) begin
			err_code = `ECS_ST_RO;
		end else if (is_acc && wb >= {1'b0, size_ff[fi]}) begin
			err_code = `ECS_ST_RANGE;
		end else if (cmd == `ECS_C_MK_FLD && size_ff[fi] != 7'h00) begin
			err_code = `ECS_ST_RESIZE;
		end else if (cmd == `ECS_C_MK_FLD &&
			(buf_ff[4][6:0] == 7'h00 || {4'h0, buf_ff[4][6:0]} > free_ff)) begin
			err_code = `ECS_ST_BAD_ARG;
		end else if (cmd == `ECS_C_RD_ANA && buf_ff[2] != `ECS_CH_A &&
			buf_ff[2] != `ECS_CH_B) begin
			err_code = `ECS_ST_BAD_ARG;
		end else begin
			err_code = `ECS_ST_OK;
		end
	end

	// internal fault events, most severe first
	always_comb begin
		ev_valid = 1'b1;
		if (wdog_restart_i) begin
			ev_code = `ECS_ST_WDOG;
		end else if (init_fault_i) begin
			// out-of-range codes 0 and 7 fold onto the highest init code, 06h
			if (init_code_i == 3'h0 || init_code_i == 3'h7) begin
				ev_code = `ECS_ST_INIT_HI;
			end else begin
				ev_code = {5'h00, init_code_i};
			end
		end else if (mt_fault_i) begin
			ev_code = `ECS_ST_MT_POS + {6'h00, mt_code_i};
		end else if (st_fault_i) begin
			ev_code = `ECS_ST_ST_POS;
		end else if (speed_fault_i) begin
			ev_code = `ECS_ST_SPEED;
		end else if (temp_fault_i) begin
			ev_code = `ECS_ST_TEMP;
		end else if (analog_fault_i) begin
			ev_code = `ECS_ST_ANALOG;
		end else if (cnt_ovf_i) begin
			ev_code = `ECS_ST_CNT_OVF;
		end else begin
			ev_valid = 1'b0;
			ev_code = `ECS_ST_OK;
		end
	end

	// answer payload for the query commands
	always_comb begin
		unique case (cmd)
			`ECS_C_STATUS: nxt_data = {8'h00, status_o};
			`ECS_C_FLD_STAT: nxt_data = {8'h00, ro_ff[fi], size_ff[fi]};
			`ECS_C_FREE: nxt_data = {5'h00, free_ff};
			`ECS_C_TYPE: nxt_data = {8'h00, TYPE_ID};
			`ECS_C_SERIAL: nxt_data = SERIAL_ID;
			default: nxt_data = 16'h0000;
		endcase
	end

	// latest status: frame fault beats event, event beats device reset clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			status_o <= `ECS_ST_OK;
		end else if (frame_go && err_code != `ECS_ST_OK) begin
			status_o <= err_code;
		end else if (ev_valid) begin
			status_o <= ev_code;
		end else if (ok_go && cmd == `ECS_C_RESET) begin
			status_o <= `ECS_ST_OK;
		end
	end

	// one answer per frame for this address; refused frames never execute
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			resp_valid_o <= 1'b0;
			resp_cmd_o <= 8'h00;
			resp_code_o <= 8'h00;
			resp_data_o <= 16'h0000;
			exec_valid_o <= 1'b0;
			exec_cmd_o <= 8'h00;
			exec_arg_o <= 32'h00000000;
			soft_reset_o <= 1'b0;
		end else begin
			resp_valid_o <= frame_go;
			exec_valid_o <= ok_go;
			soft_reset_o <= ok_go && cmd == `ECS_C_RESET;
			if (frame_go) begin
				resp_cmd_o <= cmd;
				resp_code_o <= err_code;
				resp_data_o <= ok_go ? nxt_data : 16'h0000;
				exec_cmd_o <= cmd;
				exec_arg_o <= {buf_ff[2], buf_ff[3], buf_ff[4], buf_ff[5]};
			end
		end
	end

	// guarded settings change only on accepted frames
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key_ff <= `ECS_KEY_RST;
			bus_addr_o <= `ECS_ADDR_RST;
			link_mode_o <= `ECS_MODE_RST;
		end else if (ok_go) begin
			if (cmd == `ECS_C_NEW_KEY) begin
				key_ff <= buf_ff[3];
			end
			if (cmd == `ECS_C_SET_ADDR) begin
				bus_addr_o <= buf_ff[3];
			end
			if (cmd == `ECS_C_LINK_CFG) begin
				link_mode_o <= buf_ff[3];
			end
		end
	end

	// field table; bit 7 of the size byte makes the new field read-only
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			free_ff <= FREE_BYTES;
			for (int i = 0; i < NUM_FIELDS; i++) begin
				size_ff[i] <= 7'h00;
				ro_ff[i] <= 1'b0;
			end
		end else if (ok_go && cmd == `ECS_C_MK_FLD) begin
			size_ff[fi] <= buf_ff[4][6:0];
			ro_ff[fi] <= buf_ff[4][7];
			free_ff <= free_ff - {4'h0, buf_ff[4][6:0]};
		end
	end

	sequence s_bad_frame;
		frame_go && err_code != `ECS_ST_OK;
	endsequence

	sequence s_refusal;
		resp_valid_o && !exec_valid_o && resp_code_o != `ECS_ST_OK;
	endsequence

	reject_no_exec_a: assert property (@(posedge clk_i) disable iff (rst_i)
		s_bad_frame |=> s_refusal ##0 status_o == resp_code_o)
		else $error("refused frame executed or status not recorded");

	parity_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_go && par_ff |=> resp_valid_o && resp_code_o == `ECS_ST_PARITY)
		else $error("parity fault not reported as 09h");

	chksum_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_go && !par_ff && cnt_ff >= 4'h2 && chk_ff != 8'h00
		|=> resp_code_o == `ECS_ST_CHKSUM)
		else $error("checksum fault not reported as 0Ah");

	key_guard_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_go && !par_ff && chk_ff == 8'h00 && cnt_ff == exp_len && prot &&
		buf_ff[2] != key_ff |=> resp_code_o == `ECS_ST_KEY ##0 $stable(key_ff)
		##0 $stable(bus_addr_o) ##0 $stable(link_mode_o))
		else $error("wrong key did not refuse the command");

	key_reset_a: assert property (@(posedge clk_i)
		rst_i |=> key_ff == `ECS_KEY_RST && status_o == `ECS_ST_OK)
		else $error("key or status wrong after reset");

	wdog_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wdog_restart_i && !(frame_go && err_code != `ECS_ST_OK) |=> status_o == `ECS_ST_WDOG)
		else $error("supervisor restart not reported as 07h");

	answer_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		frame_go |=> resp_valid_o ##1 !resp_valid_o)
		else $error("frame not answered exactly once");

	status_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ok_go && cmd == `ECS_C_STATUS |=> resp_data_o[7:0] == $past(status_o))
		else $error("status read returned a wrong code");

	create_free_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ok_go && cmd == `ECS_C_MK_FLD
		|=> free_ff == $past(free_ff) - {4'h0, $past(buf_ff[4][6:0])})
		else $error("free memory not reduced by new field");

	addr_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ok_go && cmd == `ECS_C_SET_ADDR |=> bus_addr_o == $past(buf_ff[3]))
		else $error("bus address not taken");

	reset_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ok_go && cmd == `ECS_C_RESET |=> soft_reset_o ##1 !soft_reset_o)
		else $error("device reset pulse wrong");

endmodule

// [test/ecs_link_master.sv]
// Purpose: drive controller model, sends whole frames to the command interpreter
// Assumes: one byte per cycle, all changes on the falling clock edge
// Notes: checksum is appended here; callers give address, command and arguments
`timescale 1ns/1ps

module ecs_link_master import ecs_pkg::*; (
	input wire logic clk_i,
	output logic rx_valid_o,
	output ecs_byte_t rx_byte_o,
	output logic rx_par_err_o,
	output logic frame_end_o
);
	// idle link at time zero
	initial begin
		rx_valid_o = 1'b0;
		rx_byte_o = 8'h00;
		rx_par_err_o = 1'b0;
		frame_end_o = 1'b0;
	end

	// bad_par marks one byte as garbled, bad_chk spoils the sum on purpose
	task automatic send(input ecs_byte_t b[$], input int bad_par, input bit bad_chk);
		ecs_byte_t chk;
		chk = 8'h00;
		foreach (b[i]) chk ^= b[i];
		b.push_back(bad_chk ? ~chk : chk);
		// caller places command and key byte where the frame expects them
		foreach (b[i]) begin
			@(negedge clk_i);
			rx_valid_o = 1'b1;
			rx_byte_o = b[i];
			rx_par_err_o = (i == bad_par);
		end
		@(negedge clk_i);
		rx_valid_o = 1'b0;
		rx_byte_o = ~rx_byte_o; // no stale byte left on the released line
		rx_par_err_o = 1'b0;
		frame_end_o = 1'b1;
		@(negedge clk_i);
		frame_end_o = 1'b0;
	endtask
endmodule

// [test/tb.sv]
// Purpose: self-checking bench of the encoder command interpreter
// Assumes: link master model sends frames, fault inputs are driven here
// Notes: answers are sampled in the one cycle where they stand
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("unexpected %s: expected %h seen %h", n, e, g); end end

module tb import ecs_pkg::*; ;
	localparam logic [7:0] TID = 8'h3c; // arbitrary value
	localparam logic [15:0] SID = 16'hbeef; // arbitrary value
	localparam logic [10:0] FREE = 11'd1792;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rx_valid, rx_par_err, frame_end;
	ecs_byte_t rx_byte;
	logic [7:0] flt = 8'h00;
	logic [2:0] init_code = 3'h0;
	logic [1:0] mt_code = 2'h0;
	logic resp_valid, exec_valid, soft_reset;
	logic [7:0] resp_cmd, resp_code, exec_cmd, bus_addr, link_mode, status;
	logic [15:0] resp_data;
	logic [31:0] exec_arg;
	int failures = 0;
	int total_checks = 0;

	// 100 MHz clock
	always #5 clk = ~clk;

	ecs_link_master m (.clk_i(clk), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte),
		.rx_par_err_o(rx_par_err), .frame_end_o(frame_end));

	ecs_top #(.NUM_FIELDS(4), .FREE_BYTES(FREE), .TYPE_ID(TID), .SERIAL_ID(SID)) dut (
		.clk_i(clk), .rst_i(rst), .rx_valid_i(rx_valid), .rx_byte_i(rx_byte),
		.rx_par_err_i(rx_par_err), .frame_end_i(frame_end), .init_fault_i(flt[0]),
		.init_code_i(init_code), .wdog_restart_i(flt[1]), .cnt_ovf_i(flt[2]),
		.speed_fault_i(flt[3]), .st_fault_i(flt[4]), .mt_fault_i(flt[5]),
		.mt_code_i(mt_code), .analog_fault_i(flt[6]), .temp_fault_i(flt[7]),
		.resp_valid_o(resp_valid), .resp_cmd_o(resp_cmd), .resp_code_o(resp_code),
		.resp_data_o(resp_data), .exec_valid_o(exec_valid), .exec_cmd_o(exec_cmd),
		.exec_arg_o(exec_arg), .soft_reset_o(soft_reset), .bus_addr_o(bus_addr),
		.link_mode_o(link_mode), .status_o(status));

	// one frame and its answer; a refused frame must leave its code in status
	task automatic frame(input ecs_byte_t b[$], input ecs_byte_t code, input int par = -1,
		input bit bad = 1'b0);
		m.send(b, par, bad);
		`CHK("answer", 1'b1, resp_valid)
		`CHK("command", b[1], resp_cmd)
		`CHK("exec command", b[1], exec_cmd)
		`CHK("code", code, resp_code)
		`CHK("accepted", code == 8'h00, exec_valid)
		`CHK("reset pulse", b[1] == 8'h53 && code == 8'h00, soft_reset)
		@(negedge clk);
		if (code != 8'h00) `CHK("status", code, status)
	endtask

	// one-cycle fault event, status follows one cycle later
	task automatic ev(input int i, input ecs_byte_t code);
		@(negedge clk);
		flt[i] = 1'b1;
		@(negedge clk);
		flt = 8'h00;
		`CHK("event status", code, status)
	endtask

	task automatic t_basic();
		`CHK("status", 8'h00, status)
		`CHK("address", 8'h40, bus_addr)
		`CHK("mode", 8'he4, link_mode)
		frame('{8'h40, 8'h50}, 8'h00);
		`CHK("status data", 16'h0000, resp_data)
		frame('{8'h40, 8'h52}, 8'h00);
		`CHK("type", TID, resp_data[7:0])
		frame('{8'h40, 8'h56}, 8'h00);
		`CHK("serial", SID, resp_data)
		frame('{8'h40, 8'h4e}, 8'h00);
		`CHK("free", {5'h00, FREE}, resp_data)
		$display("basic queries done");
	endtask

	task automatic t_proto();
		frame('{8'h40, 8'h52}, 8'h09, 2);
		frame('{8'h40, 8'h52}, 8'h0a, -1, 1'b1);
		frame('{8'h40, 8'h41}, 8'h0b);
		frame('{8'h40, 8'h52, 8'h00}, 8'h0c);
		frame('{8'h40, 8'h44, 8'h12}, 8'h0d);
		frame('{8'h40, 8'h44, 8'h48}, 8'h00);
		frame('{8'h40, 8'h44, 8'hf0}, 8'h00);
		// a frame for another address gets no answer at all
		m.send('{8'h41, 8'h50}, -1, 1'b0);
		`CHK("foreign answer", 1'b0, resp_valid)
		$display("protocol faults done");
	endtask

	task automatic t_key();
		frame('{8'h40, 8'h55, 8'h54, 8'h41}, 8'h0f);
		`CHK("address kept", 8'h40, bus_addr)
		frame('{8'h40, 8'h43, 8'h00, 8'h01, 8'h02, 8'h03, 8'h04}, 8'h0f);
		frame('{8'h40, 8'h55, 8'h55, 8'h41}, 8'h00);
		`CHK("address", 8'h41, bus_addr)
		frame('{8'h41, 8'h57, 8'h55, 8'ha5}, 8'h00);
		`CHK("mode", 8'ha5, link_mode)
		`CHK("arg", 16'h55a5, exec_arg[31:16])
		frame('{8'h41, 8'h55, 8'h55, 8'h40}, 8'h00);
		$display("key test done");
	endtask

	task automatic t_field();
		frame('{8'h40, 8'h4a, 8'h00, 8'h00}, 8'h12);
		frame('{8'h40, 8'h4b, 8'h55, 8'h09, 8'h00, 8'h11}, 8'h12);
		frame('{8'h40, 8'h4d, 8'h55, 8'h00, 8'h82}, 8'h00);
		frame('{8'h40, 8'h4d, 8'h55, 8'h00, 8'h04}, 8'h10);
		frame('{8'h40, 8'h4b, 8'h55, 8'h00, 8'h00, 8'h11}, 8'h0e);
		frame('{8'h40, 8'h4b, 8'h33, 8'h00, 8'h00, 8'h11}, 8'h0f);
		frame('{8'h40, 8'h4a, 8'h00, 8'h02}, 8'h11);
		frame('{8'h40, 8'h4d, 8'h55, 8'h01, 8'h00}, 8'h0d);
		frame('{8'h40, 8'h4d, 8'h55, 8'h01, 8'h03}, 8'h00);
		frame('{8'h40, 8'h4b, 8'h55, 8'h01, 8'h02, 8'h77}, 8'h00);
		frame('{8'h40, 8'h4c, 8'h01}, 8'h00);
		`CHK("field status", 16'h0003, resp_data)
		frame('{8'h40, 8'h4f, 8'h55, 8'h66}, 8'h00);
		frame('{8'h40, 8'h4b, 8'h55, 8'h01, 8'h02, 8'h00}, 8'h0f);
		// word storage sits behind the execution port, so the read hands on its operands
		frame('{8'h40, 8'h4a, 8'h01, 8'h02}, 8'h00);
		`CHK("read args", 16'h0102, exec_arg[31:16])
		frame('{8'h40, 8'h4f, 8'h66, 8'h55}, 8'h00);
		$display("data field test done");
	endtask

	task automatic t_events();
		init_code = 3'h1;
		ev(0, 8'h01);
		init_code = 3'h6;
		ev(0, 8'h06);
		ev(1, 8'h07);
		ev(2, 8'h08);
		ev(3, 8'h1f);
		ev(4, 8'h20);
		mt_code = 2'h2;
		ev(5, 8'h23);
		ev(6, 8'h1c);
		ev(7, 8'h1e);
		frame('{8'h40, 8'h50}, 8'h00);
		`CHK("status data", 8'h1e, resp_data[7:0])
		frame('{8'h40, 8'h53}, 8'h00);
		`CHK("cleared", 8'h00, status)
		$display("fault event test done");
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// main sequence after ten reset cycles
	initial begin
		repeat (10) @(negedge clk);
		rst = 1'b0;
		t_basic();
		t_proto();
		t_key();
		t_field();
		t_events();
		give_verdict();
	end

	// tests need under 1000 cycles, so 20 us means a hang
	initial begin
		#20000;
		failures++;
		give_verdict();
	end
endmodule
